// ---- dv/testbench.sv ----
// self-checking bench for the 8-bit timer waveform logic
`timescale 1ns/1ns
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin \
    num_errors++; $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module testbench;
    // ----------
    // signals
    // ----------
    reg        clk, rst_b, tick, force_compare_a_strobe, count_wr;
    reg  [2:0] waveform_mode_sel;
    reg  [1:0] output_a_action_sel, output_b_action_sel;
    reg  [7:0] count_wr_data, compare_a_wr_data;
    reg        compare_a_wr, overflow_clr, compare_a_clr, port_a_data;
    reg        pin_a_dir_out, pin_b_dir_out, port_b_data;
    wire [7:0] count_value, compare_a_value;
    wire       overflow_flag, compare_a_flag, compare_output_a, level_a;
    wire       pin_a_out, pin_a_oe, pin_b_out, pin_b_oe;
    wire [7:0] compare_b_value;
    wire       compare_b_flag, compare_output_b;
    int        num_errors = 0;
    int        check_count = 0;
    tw8_timer #(.WIDTH(8)) DUT (
        .clk(clk), .rst_b(rst_b), .tick(tick),
        .waveform_mode_sel(waveform_mode_sel),
        .output_a_action_sel(output_a_action_sel),
        .output_b_action_sel(output_b_action_sel),
        .force_compare_a_strobe(force_compare_a_strobe),
        .force_compare_b_strobe(force_compare_a_strobe),
        .count_wr(count_wr), .count_wr_data(count_wr_data),
        .compare_a_wr(compare_a_wr), .compare_a_wr_data(compare_a_wr_data),
        .compare_b_wr(compare_a_wr), .compare_b_wr_data(compare_a_wr_data),
        .overflow_clr(overflow_clr), .compare_a_clr(compare_a_clr),
        .compare_b_clr(compare_a_clr), .pin_a_dir_out(pin_a_dir_out),
        .pin_b_dir_out(pin_b_dir_out), .port_a_data(port_a_data),
        .port_b_data(port_b_data), .count_value(count_value),
        .compare_a_value(compare_a_value),
        .compare_b_value(compare_b_value),
        .overflow_flag(overflow_flag), .compare_a_flag(compare_a_flag),
        .compare_b_flag(compare_b_flag),
        .compare_output_a(compare_output_a),
        .compare_output_b(compare_output_b),
        .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
        .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe));
    tw8_pin_load load_a (.pin_out(pin_a_out), .pin_oe(pin_a_oe),
        .level(level_a));
    // ----------
    // drivers, all called and returning at a falling edge
    // ----------
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task run(input int n);
        tick = 1'h1;
        cyc(n);
        tick = 1'h0;
    endtask
    task wcnt(input [7:0] v);
        count_wr = 1'h1;
        count_wr_data = v;
        cyc(1);
        count_wr = 1'h0;
    endtask
    task wcmp(input [7:0] v);
        compare_a_wr = 1'h1;
        compare_a_wr_data = v;
        cyc(1);
        compare_a_wr = 1'h0;
    endtask
    task frc;
        force_compare_a_strobe = 1'h1;
        cyc(1);
        force_compare_a_strobe = 1'h0;
    endtask
    task clr;
        {overflow_clr, compare_a_clr} = 2'h3;
        cyc(1);
        {overflow_clr, compare_a_clr} = 2'h0;
    endtask
    // ----------
    // scenarios
    // ----------
    task s_normal;
        waveform_mode_sel = 3'h0;
        wcnt(8'hFE);
        `CHK(count_value, 8'hFE)
        run(2);
        `CHK(count_value, 8'h00)
        `CHK(overflow_flag, 1'h1)
        clr;
        `CHK(overflow_flag, 1'h0)
    endtask
    task s_force;
        logic [1:0] acts [5] = '{2'h3, 2'h2, 2'h1, 2'h1, 2'h0};
        logic       exp [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0};
        {pin_a_dir_out, port_a_data} = 2'h3;
        foreach (acts[i]) begin
            output_a_action_sel = acts[i];
            frc;
            `CHK(compare_output_a, exp[i])
            `CHK(compare_a_flag, 1'h0)
        end
        cyc(1);
        `CHK(level_a, 1'h1)
        pin_a_dir_out = 1'h0;
        cyc(2);
        `CHK(level_a, 1'h0)
        pin_a_dir_out = 1'h1;
    endtask
    task s_ctc;
        waveform_mode_sel = 3'h2;
        output_a_action_sel = 2'h1;
        wcmp(8'h03);
        wcnt(8'h00);
        clr;
        run(3);
        `CHK(compare_output_a, 1'h0)
        run(1);
        `CHK(count_value, 8'h00)
        `CHK(compare_a_flag, 1'h1)
        `CHK(compare_output_a, 1'h1)
        `CHK(compare_b_flag, 1'h1)
        wcnt(8'h10);
        clr;
        run(8'hF0);
        `CHK(count_value, 8'h00)
        `CHK(overflow_flag, 1'h1)
        `CHK(compare_a_flag, 1'h0)
    endtask
    task s_block;
        waveform_mode_sel = 3'h0;
        wcmp(8'h05);
        wcnt(8'h05);
        clr;
        run(1);
        `CHK(count_value, 8'h06)
        `CHK(compare_a_flag, 1'h0)
        `CHK(compare_output_a, 1'h1)
    endtask
    task s_fast;
        frc;
        waveform_mode_sel = 3'h3;
        output_a_action_sel = 2'h2;
        wcmp(8'h40);
        `CHK(compare_a_value, 8'h05)
        wcnt(8'hFF);
        clr;
        run(1);
        `CHK(compare_a_value, 8'h40)
        `CHK(compare_b_value, 8'h40)
        `CHK(overflow_flag, 1'h1)
        `CHK(compare_output_a, 1'h1)
        run(8'h41);
        `CHK(compare_output_a, 1'h0)
        run(8'hBF);
        `CHK(count_value, 8'h00)
        `CHK(compare_output_a, 1'h1)
        run(8'h41);
        output_a_action_sel = 2'h3;
        run(8'hBF);
        `CHK(count_value, 8'h00)
        run(8'h41);
        `CHK(compare_output_a, 1'h1)
        run(8'hBF);
        `CHK(compare_output_a, 1'h0)
    endtask
    task s_top;
        waveform_mode_sel = 3'h7;
        {output_a_action_sel, output_b_action_sel} = 4'h5;
        {pin_b_dir_out, port_b_data} = 2'h2;
        run(8'h41);
        `CHK(count_value, 8'h00)
        `CHK(compare_output_a, 1'h1)
        `CHK(compare_output_b, 1'h0)
        `CHK(pin_b_out, 1'h0)
        `CHK(pin_b_oe, 1'h1)
        port_a_data = 1'h0;
        waveform_mode_sel = 3'h3;
        cyc(2);
        `CHK(pin_a_out, 1'h0)
    endtask
    task s_edge;
        output_a_action_sel = 2'h2;
        wcmp(8'h00);
        wcnt(8'hFF);
        run(1);
        `CHK(compare_output_a, 1'h1)
        run(1);
        `CHK(compare_output_a, 1'h0)
        wcmp(8'hFF);
        run(8'hFF);
        `CHK(compare_output_a, 1'h1)
        run(9'h100);
        `CHK(compare_output_a, 1'h1)
    endtask
    task print_verdict;
        if (num_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ----------
    // clock, reset, sequence
    // ----------
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    initial begin
        #2000000;
        num_errors++;
        print_verdict;
    end
    initial begin
        {tick, force_compare_a_strobe, count_wr, compare_a_wr} = 4'h0;
        {overflow_clr, compare_a_clr, port_a_data, port_b_data} = 4'h0;
        {pin_a_dir_out, pin_b_dir_out, rst_b} = 3'h0;
        {waveform_mode_sel, output_a_action_sel} = 5'h00;
        output_b_action_sel = 2'h0;
        {count_wr_data, compare_a_wr_data} = 16'h0000;
        cyc(8);
        rst_b = 1'h1;
        cyc(1);
        s_normal;
        s_force;
        s_ctc;
        s_block;
        s_fast;
        s_top;
        s_edge;
        print_verdict;
    end
endmodule // testbench
bind tw8_timer tw8_timer_sva #(.WIDTH(WIDTH)) u_sva (.clk(clk),
    .rst_b(rst_b), .tick(tick), .waveform_mode_sel(waveform_mode_sel),
    .output_a_action_sel(output_a_action_sel),
    .force_compare_a_strobe(force_compare_a_strobe), .count_wr(count_wr),
    .compare_a_clr(compare_a_clr), .pin_a_dir_out(pin_a_dir_out),
    .count_value(count_value), .compare_a_value(compare_a_value),
    .overflow_flag(overflow_flag), .compare_a_flag(compare_a_flag),
    .compare_output_a(compare_output_a), .pin_a_oe(pin_a_oe));

// ---- dv/tw8_pin_load.sv ----
// load model of the external circuit on one compare output pin
`timescale 1ns/1ns
module tw8_pin_load #(
    parameter PULL = 1'h0
) (
    input wire pin_out,
    input wire pin_oe,
    output wire level
);
    // a released pin falls to the pull level, never keeps the last value
    assign level = pin_oe ? pin_out : PULL;
endmodule // tw8_pin_load

// ---- dv/tw8_timer_sva.sv ----
// assertion checker for the 8-bit timer waveform logic
`timescale 1ns/1ns
module tw8_timer_sva #(
    parameter WIDTH = 8
) (
    input wire             clk,
    input wire             rst_b,
    input wire             tick,
    input wire [2:0]       waveform_mode_sel,
    input wire [1:0]       output_a_action_sel,
    input wire             force_compare_a_strobe,
    input wire             count_wr,
    input wire             compare_a_clr,
    input wire             pin_a_dir_out,
    input wire [WIDTH-1:0] count_value,
    input wire [WIDTH-1:0] compare_a_value,
    input wire             overflow_flag,
    input wire             compare_a_flag,
    input wire             compare_output_a,
    input wire             pin_a_oe
);
    // ----------
    // helpers
    // ----------
    // a counter write blocks matches until one tick has gone by
    logic blk;
    wire  nrm = waveform_mode_sel == 3'h0;
    wire  clear_on_match_mode = waveform_mode_sel == 3'h2;
    wire  stp = tick && !count_wr;
    wire  hit = stp && !blk && count_value == compare_a_value;
    wire  idle_act = output_a_action_sel == 2'h0;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) blk <= 1'h0;
        else if (count_wr) blk <= 1'h1;
        else if (tick) blk <= 1'h0;
    end
    // ----------
    // properties
    // ----------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    a_match_flag: assert property (hit |=> compare_a_flag)
        else $error("compare A flag not raised after match");
    a_write_block: assert property (blk && stp && !compare_a_flag
        |=> !compare_a_flag) else $error("match not blocked after write");
    a_normal_step: assert property (nrm && stp
        |=> count_value == WIDTH'($past(count_value) + 1))
        else $error("normal count did not step by one");
    a_normal_ovf: assert property (nrm && stp && &count_value
        |=> overflow_flag) else $error("overflow not set on wrap");
    a_ctc_clear: assert property (clear_on_match_mode && hit
        |=> count_value == '0) else $error("count not cleared at top");
    a_fast_wrap: assert property (waveform_mode_sel == 3'h3
        && stp && &count_value |=> count_value == '0 && overflow_flag)
        else $error("fast mode did not wrap from top");
    a_ctc_toggle: assert property (clear_on_match_mode && hit
        && !force_compare_a_strobe && output_a_action_sel == 2'h1
        |=> compare_output_a != $past(compare_output_a))
        else $error("output A did not toggle on match");
    a_none_hold: assert property ((nrm || clear_on_match_mode) && idle_act
        |=> $stable(compare_output_a))
        else $error("output changed with no action set");
    a_dir_gate: assert property (!pin_a_dir_out |=> !pin_a_oe)
        else $error("pin enabled while direction is input");
    a_force_quiet: assert property (force_compare_a_strobe && !tick
        && !compare_a_clr |=> $stable(compare_a_flag))
        else $error("force strobe changed the compare flag");
endmodule // tw8_timer_sva

// ---- src/tw8_cmp_chan.v ----
// one compare channel: buffer, active value and equality check
`timescale 1ns/1ns
module tw8_cmp_chan #(
    parameter WIDTH = 8
) (
    clk,
    rst_b,
    wr,
    wr_data,
    buffered,
    update,
    count,
    active,
    equal
);
    input  wire             clk;
    input  wire             rst_b;
    input  wire             wr;
    input  wire [WIDTH-1:0] wr_data;
    input  wire             buffered;
    input  wire             update;
    input  wire [WIDTH-1:0] count;
    output reg  [WIDTH-1:0] active;
    output wire             equal;

    reg [WIDTH-1:0] shadow;

    // ----------------------------------------------------------------
    // buffer and active compare value
    // ----------------------------------------------------------------
    // a write landing with the update still reaches the active value
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shadow <= {WIDTH{1'b0}};
            active <= {WIDTH{1'b0}};
        end else begin
            if (wr) begin
                shadow <= wr_data;
            end
            if (wr && !buffered) begin
                active <= wr_data;
            end else if (buffered && update) begin
                active <= wr ? wr_data : shadow;
            end
        end
    end

    assign equal = (count == active);

endmodule // tw8_cmp_chan

// ---- src/tw8_consts.vh ----
// constants for the 8-bit timer waveform mode logic
//
// Behaviour
// - action code zero leaves compare output unchanged
// - new action code applies at next match
// - force strobe applies action now, non-PWM
// - only waveform mode and compare A (top in clear-on-match and mode 7) shape the count sequence
// - normal mode always increments, wraps FF to 00
// - normal overflow flag set as count hits zero
// - counter write accepted at any time
// - clear-on-match mode clears count at compare A
// - compare A unbuffered there; late value wraps first
// - compare A flag raised at each top there unless a counter write blocks the match
// - clear-on-match action one toggles output A
// - clear-on-match overflow set on MAX to 00
// - fast PWM top is FF or compare A
// - fast PWM counts to top, clears next tick
// - fast PWM codes two/three clear/set, bottom reverses
// - fast PWM overflow flag set at top
// - fast PWM toggle only A with mode bit2
// - bottom compare spikes; MAX compare gives level
// - fast PWM compare values double buffered
// - pin driven only when direction is output
// - top FF gives 256-tick PWM period
// - match sets compare flag next timer tick
// - counter write blocks next tick's matches
// - buffered compare copied only at top/bottom
`ifndef TW8_CONSTS_VH
`define TW8_CONSTS_VH

// ----------------------------------------------------------------
// waveform mode codes
// ----------------------------------------------------------------
`define TW8_MODE_NORMAL   3'h0
`define TW8_MODE_CTC      3'h2
`define TW8_MODE_FAST_MAX 3'h3
`define TW8_MODE_FAST_OCA 3'h7
`define TW8_MODE_BIT2     2

// ----------------------------------------------------------------
// output action codes
// ----------------------------------------------------------------
`define TW8_ACT_NONE      2'h0
`define TW8_ACT_TOGGLE    2'h1
`define TW8_ACT_CLEAR     2'h2
`define TW8_ACT_SET       2'h3

// ----------------------------------------------------------------
// count limits and reset values
// ----------------------------------------------------------------
`define TW8_COUNT_MAX     8'hFF
`define TW8_COUNT_BOTTOM  8'h00
`define TW8_COUNT_RST     8'h00
`define TW8_COMPARE_RST   8'h00
`define TW8_OC_RST        1'b0
`define TW8_PERIOD_MAX    256

`endif

// ---- src/tw8_oc_unit.v ----
// compare output register and pin override for one channel
`timescale 1ns/1ns
`include "tw8_consts.vh"
module tw8_oc_unit #(
    parameter CAN_PWM_TOGGLE = 1
) (
    clk,
    rst_b,
    tick,
    match,
    force_strobe,
    bottom_evt,
    non_pwm,
    fast_pwm,
    mode_bit2,
    action,
    dir_out,
    port_data,
    oc,
    pin_out,
    pin_oe
);
    input  wire       clk;
    input  wire       rst_b;
    input  wire       tick;
    input  wire       match;
    input  wire       force_strobe;
    input  wire       bottom_evt;
    input  wire       non_pwm;
    input  wire       fast_pwm;
    input  wire       mode_bit2;
    input  wire [1:0] action;
    input  wire       dir_out;
    input  wire       port_data;
    output reg        oc;
    output reg        pin_out;
    output reg        pin_oe;

    reg  next_oc;
    wire toggle_ok;
    wire connected;

    assign toggle_ok = (CAN_PWM_TOGGLE != 0) && mode_bit2;
    assign connected = (action != `TW8_ACT_NONE) &&
        !(fast_pwm && action == `TW8_ACT_TOGGLE && !toggle_ok);

    // set, clear or toggle in the non-PWM sense
    function apply_action;
        input [1:0] act;
        input       cur;
        begin
            if (act == `TW8_ACT_TOGGLE) begin
                apply_action = ~cur;
            end else if (act == `TW8_ACT_CLEAR) begin
                apply_action = 1'b0;
            end else if (act == `TW8_ACT_SET) begin
                apply_action = 1'b1;
            end else begin
                apply_action = cur;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // next compare output value
    // ----------------------------------------------------------------
    always @* begin
        next_oc = oc;
        if (force_strobe && non_pwm) begin
            next_oc = apply_action(action, oc);
        end else if (tick && fast_pwm) begin
            // bottom wins so a compare at top gives a steady level
            if (bottom_evt && action[1]) begin
                next_oc = ~action[0];
            end else if (match && action[1]) begin
                next_oc = action[0];
            end else if (match && toggle_ok &&
                         action == `TW8_ACT_TOGGLE) begin
                next_oc = ~oc;
            end
        end else if (tick && !fast_pwm && match) begin
            next_oc = apply_action(action, oc);
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            oc      <= `TW8_OC_RST;
            pin_out <= 1'b0;
            pin_oe  <= 1'b0;
        end else begin
            oc      <= next_oc;
            pin_out <= connected ? next_oc : port_data;
            pin_oe  <= dir_out;
        end
    end

endmodule // tw8_oc_unit

// ---- src/tw8_timer.v ----
// 8-bit timer counter with normal, clear-on-match and fast PWM modes
`timescale 1ns/1ns
`include "tw8_consts.vh"
module tw8_timer #(
    parameter WIDTH = 8
) (
    clk,
    rst_b,
    tick,
    waveform_mode_sel,
    output_a_action_sel,
    output_b_action_sel,
    force_compare_a_strobe,
    force_compare_b_strobe,
    count_wr,
    count_wr_data,
    compare_a_wr,
    compare_a_wr_data,
    compare_b_wr,
    compare_b_wr_data,
    overflow_clr,
    compare_a_clr,
    compare_b_clr,
    pin_a_dir_out,
    pin_b_dir_out,
    port_a_data,
    port_b_data,
    count_value,
    compare_a_value,
    compare_b_value,
    overflow_flag,
    compare_a_flag,
    compare_b_flag,
    compare_output_a,
    compare_output_b,
    pin_a_out,
    pin_a_oe,
    pin_b_out,
    pin_b_oe
);
    input  wire             clk;
    input  wire             rst_b;
    input  wire             tick;
    input  wire [2:0]       waveform_mode_sel;
    input  wire [1:0]       output_a_action_sel;
    input  wire [1:0]       output_b_action_sel;
    input  wire             force_compare_a_strobe;
    input  wire             force_compare_b_strobe;
    input  wire             count_wr;
    input  wire [WIDTH-1:0] count_wr_data;
    input  wire             compare_a_wr;
    input  wire [WIDTH-1:0] compare_a_wr_data;
    input  wire             compare_b_wr;
    input  wire [WIDTH-1:0] compare_b_wr_data;
    input  wire             overflow_clr;
    input  wire             compare_a_clr;
    input  wire             compare_b_clr;
    input  wire             pin_a_dir_out;
    input  wire             pin_b_dir_out;
    input  wire             port_a_data;
    input  wire             port_b_data;
    output reg  [WIDTH-1:0] count_value;
    output wire [WIDTH-1:0] compare_a_value;
    output wire [WIDTH-1:0] compare_b_value;
    output reg              overflow_flag;
    output reg              compare_a_flag;
    output reg              compare_b_flag;
    output wire             compare_output_a;
    output wire             compare_output_b;
    output wire             pin_a_out;
    output wire             pin_a_oe;
    output wire             pin_b_out;
    output wire             pin_b_oe;

    // ----------------------------------------------------------------
    // mode decode
    // ----------------------------------------------------------------
    // phase correct and reserved codes are not built here; they
    // count and drive outputs as in normal mode
    function is_fast_pwm;
        input [2:0] mode;
        begin
            is_fast_pwm = (mode == `TW8_MODE_FAST_MAX) ||
                          (mode == `TW8_MODE_FAST_OCA);
        end
    endfunction

    function top_is_compare;
        input [2:0] mode;
        begin
            top_is_compare = (mode == `TW8_MODE_CTC) ||
                             (mode == `TW8_MODE_FAST_OCA);
        end
    endfunction

    wire             fast_pwm;
    wire             non_pwm;
    wire             mode_bit2;
    wire             clear_on_top;
    wire [WIDTH-1:0] top_value;
    wire             at_top;
    wire             at_max;
    wire             bottom_evt;
    wire             equal_a;
    wire             equal_b;
    wire             match_a;
    wire             match_b;
    wire             overflow_evt;

    reg  [WIDTH-1:0] next_count;
    reg              match_block;

    // output action codes never enter the counting path
    assign fast_pwm     = is_fast_pwm(waveform_mode_sel);
    assign non_pwm      = !fast_pwm;
    assign mode_bit2    = waveform_mode_sel[`TW8_MODE_BIT2];
    assign clear_on_top = fast_pwm ||
                          (waveform_mode_sel == `TW8_MODE_CTC);

    // ----------------------------------------------------------------
    // top selection
    // ----------------------------------------------------------------
    assign top_value = top_is_compare(waveform_mode_sel) ?
                       compare_a_value : `TW8_COUNT_MAX;
    assign at_top    = (count_value == top_value);
    assign at_max    = (count_value == `TW8_COUNT_MAX);

    // the tick that leaves top is the pass to bottom
    assign bottom_evt = tick && fast_pwm && at_top;

    // ----------------------------------------------------------------
    // compare channels
    // ----------------------------------------------------------------
    // non-PWM writes go straight through, so a compare value set
    // below the count is only met after the wrap
    tw8_cmp_chan #(
        .WIDTH    (WIDTH)
    ) u_cmp_a (
        .clk      (clk),
        .rst_b    (rst_b),
        .wr       (compare_a_wr),
        .wr_data  (compare_a_wr_data),
        .buffered (fast_pwm),
        .update   (bottom_evt),
        .count    (count_value),
        .active   (compare_a_value),
        .equal    (equal_a)
    );

    tw8_cmp_chan #(
        .WIDTH    (WIDTH)
    ) u_cmp_b (
        .clk      (clk),
        .rst_b    (rst_b),
        .wr       (compare_b_wr),
        .wr_data  (compare_b_wr_data),
        .buffered (fast_pwm),
        .update   (bottom_evt),
        .count    (count_value),
        .active   (compare_b_value),
        .equal    (equal_b)
    );

    // ----------------------------------------------------------------
    // match blocking after a counter write
    // ----------------------------------------------------------------
    // held until a tick consumes it, so a stopped timer keeps it
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            match_block <= 1'b0;
        end else if (count_wr) begin
            match_block <= 1'b1;
        end else if (tick) begin
            match_block <= 1'b0;
        end
    end

    assign match_a = equal_a && !match_block;
    assign match_b = equal_b && !match_block;

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    always @* begin
        next_count = count_value;
        if (count_wr) begin
            next_count = count_wr_data;
        end else if (tick) begin
            if (clear_on_top && at_top) begin
                next_count = `TW8_COUNT_BOTTOM;
            end else begin
                // plain 8-bit wrap; 256 ticks per pass at top FF
                next_count = count_value + 1'b1;
            end
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count_value <= `TW8_COUNT_RST;
        end else begin
            count_value <= next_count;
        end
    end

    // ----------------------------------------------------------------
    // overflow flag
    // ----------------------------------------------------------------
    // non-PWM: the tick that carries MAX into zero; fast PWM: top
    assign overflow_evt = tick && !count_wr &&
                          (fast_pwm ? at_top : at_max);

    // set beats a clear in the same cycle so no event is lost
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            overflow_flag <= 1'b0;
        end else if (overflow_evt) begin
            overflow_flag <= 1'b1;
        end else if (overflow_clr) begin
            overflow_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // compare flags
    // ----------------------------------------------------------------
    // forced compares never reach these flags
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            compare_a_flag <= 1'b0;
        end else if (tick && match_a) begin
            compare_a_flag <= 1'b1;
        end else if (compare_a_clr) begin
            compare_a_flag <= 1'b0;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            compare_b_flag <= 1'b0;
        end else if (tick && match_b) begin
            compare_b_flag <= 1'b1;
        end else if (compare_b_clr) begin
            compare_b_flag <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // compare output units
    // ----------------------------------------------------------------
    // only output A may toggle in fast PWM
    tw8_oc_unit #(
        .CAN_PWM_TOGGLE (1)
    ) u_oc_a (
        .clk            (clk),
        .rst_b          (rst_b),
        .tick           (tick),
        .match          (match_a),
        .force_strobe   (force_compare_a_strobe),
        .bottom_evt     (bottom_evt),
        .non_pwm        (non_pwm),
        .fast_pwm       (fast_pwm),
        .mode_bit2      (mode_bit2),
        .action         (output_a_action_sel),
        .dir_out        (pin_a_dir_out),
        .port_data      (port_a_data),
        .oc             (compare_output_a),
        .pin_out        (pin_a_out),
        .pin_oe         (pin_a_oe)
    );

    tw8_oc_unit #(
        .CAN_PWM_TOGGLE (0)
    ) u_oc_b (
        .clk            (clk),
        .rst_b          (rst_b),
        .tick           (tick),
        .match          (match_b),
        .force_strobe   (force_compare_b_strobe),
        .bottom_evt     (bottom_evt),
        .non_pwm        (non_pwm),
        .fast_pwm       (fast_pwm),
        .mode_bit2      (mode_bit2),
        .action         (output_b_action_sel),
        .dir_out        (pin_b_dir_out),
        .port_data      (port_b_data),
        .oc             (compare_output_b),
        .pin_out        (pin_b_out),
        .pin_oe         (pin_b_oe)
    );

endmodule // tw8_timer
